//--- verification/tb_top.sv
// Self-checking bench for the serial control and address recognition block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import uar_pkg::*;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic tx_stop_begin = 1'b0;
    logic [7:0] reg_rdata, rx_data;
    logic rx_frame_done, rx_bit9, rx_stop_ok, rx_enable, tx_bit9, irq;
    logic [1:0] mode_sel;
    int n_mismatch = 0;
    int checks = 0;
    int cycles = 0;
    always #12.5 sys_clk = ~sys_clk;
    uar_ctrl uar_ctrl_inst (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_frame_done(rx_frame_done),
        .rx_data(rx_data), .rx_bit9(rx_bit9), .rx_stop_ok(rx_stop_ok), .tx_start(1'b0),
        .tx_stop_begin(tx_stop_begin), .mode_sel(mode_sel), .rx_enable(rx_enable), .tx_bit9(tx_bit9), .irq(irq));
    uar_node_model uar_node_model_inst (.sys_clk(sys_clk), .rx_frame_done(rx_frame_done), .rx_data(rx_data),
        .rx_bit9(rx_bit9), .rx_stop_ok(rx_stop_ok));
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata & m, exp);
    endtask
    // Sends one frame, checks the receive flag, then rewrites control to clear it.
    task automatic fr(input logic [7:0] d, input logic b9, input logic stop, input logic [7:0] ctl, input logic ri);
        uar_node_model_inst.send(d, b9, stop);
        rd(UAR_CTRL_OFF, 8'h01, {7'h0, ri});
        wr(UAR_CTRL_OFF, ctl);
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            finish_test();
        end
    end
    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge sys_clk);
        reset_n <= 1'b1;
        rd(UAR_CTRL_OFF, 8'hff, UAR_CTRL_RESET);
        rd(8'h10, 8'hff, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(UAR_CTRL_OFF, 8'(i << 6));
            chk({6'h0, mode_sel}, 8'(i));
        end
        wr(UAR_CTRL_OFF, 8'hd0);
        fr(8'h55, 1'b0, 1'b1, 8'h40, 1'b1);
        fr(8'haa, 1'b1, 1'b1, 8'h40, 1'b0);
        rd(UAR_RXDATA_OFF, 8'hff, 8'h55);
        wr(UAR_STADDR_OFF, 8'hc0);
        wr(UAR_SMASK_OFF, 8'hfd);
        wr(UAR_CTRL_OFF, 8'hf0);
        fr(8'hc2, 1'b1, 1'b1, 8'hf0, 1'b1);
        fr(8'hc1, 1'b1, 1'b1, 8'hf0, 1'b0);
        fr(8'hff, 1'b1, 1'b1, 8'hb0, 1'b1);
        fr(8'hc2, 1'b1, 1'b1, 8'hf0, 1'b1);
        fr(8'hc2, 1'b0, 1'b1, 8'h70, 1'b0);
        fr(8'hc2, 1'b0, 1'b0, 8'h70, 1'b0);
        fr(8'hc2, 1'b0, 1'b1, 8'h30, 1'b1);
        fr(8'h12, 1'b0, 1'b1, 8'hc8, 1'b1);
        chk({7'h0, tx_bit9}, 8'h01);
        @(posedge sys_clk);
        tx_stop_begin <= 1'b1;
        @(posedge sys_clk);
        tx_stop_begin <= 1'b0;
        rd(UAR_CTRL_OFF, 8'h02, 8'h02);
        wr(UAR_CTRL_OFF, 8'hd0);
        rd(UAR_CTRL_OFF, 8'h0a, 8'h00);
        rd(UAR_IRQ_STAT_OFF, 8'h07, 8'h07);
        wr(UAR_IRQ_MASK_OFF, 8'h05);
        fr(8'h21, 1'b0, 1'b1, 8'hd0, 1'b1);
        chk({7'h0, irq}, 8'h01);
        rd(UAR_IRQ_STAT_OFF, 8'h07, 8'h01);
        chk({7'h0, irq}, 8'h00);
        wr(UAR_IRQ_MASK_OFF, 8'h04);
        fr(8'h22, 1'b0, 1'b1, 8'h50, 1'b1);
        chk({7'h0, irq}, 8'h00);
        wr(UAR_AUX_OFF, 8'h01);
        uar_node_model_inst.send(8'h33, 1'b0, 1'b0);
        rd(UAR_CTRL_OFF, 8'h80, 8'h80);
        chk({6'h0, mode_sel}, 8'h01);
        chk({7'h0, irq}, 8'h01);
        uar_node_model_inst.send(8'h34, 1'b0, 1'b1);
        rd(UAR_CTRL_OFF, 8'h80, 8'h80);
        wr(UAR_CTRL_OFF, 8'h50);
        rd(UAR_CTRL_OFF, 8'h80, 8'h00);
        finish_test();
    end
endmodule
`default_nettype wire

//--- verification/uar_node_model.sv
// Remote serial node model that hands finished frames to the receive side.
`timescale 1ns/1ps
`default_nettype none
module uar_node_model (
    input wire logic sys_clk,
    output logic rx_frame_done,
    output logic [7:0] rx_data,
    output logic rx_bit9,
    output logic rx_stop_ok
);
    initial begin
        rx_frame_done = 1'b0;
        rx_data = 8'h00;
        rx_bit9 = 1'b0;
        rx_stop_ok = 1'b0;
    end
    // Idle lines carry the inverse of the last frame, so stale contents never look valid.
    task automatic send(input logic [7:0] d, input logic b9, input logic stop);
        @(posedge sys_clk);
        rx_frame_done <= 1'b1;
        rx_data <= d;
        rx_bit9 <= b9;
        rx_stop_ok <= stop;
        @(posedge sys_clk);
        rx_frame_done <= 1'b0;
        rx_data <= ~d;
        rx_bit9 <= ~b9;
        rx_stop_ok <= ~stop;
    endtask
endmodule
`default_nettype wire

//--- verilog/uar_ctrl.sv
// Serial port control register, receive qualification and address recognition.
`timescale 1ns/1ps
`default_nettype none
module uar_ctrl (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic rx_frame_done,
    input wire logic [7:0] rx_data,
    input wire logic rx_bit9,
    input wire logic rx_stop_ok,
    input wire logic tx_start,
    input wire logic tx_stop_begin,
    output logic [1:0] mode_sel,
    output logic rx_enable,
    output logic tx_bit9,
    output logic irq
);
    import uar_pkg::*;

    logic [7:0] ctrl_reg, ctrl_next;
    logic ferr_reg, ferr_next;
    logic mode0_reg, mode0_next;
    logic sel_reg, sel_next;
    logic [7:0] staddr_reg, staddr_next;
    logic [7:0] smask_reg, smask_next;
    logic [7:0] rxd_reg, rxd_next;
    logic [2:0] ist_reg, ist_next;
    logic [2:0] imask_reg, imask_next;
    logic [7:0] rdata_reg, rdata_next;
    logic [1:0] mode;
    logic accept, addr_hit, rx_set, ferr_set;
    logic ctrl_wr, stat_rd;

    // ----------------------------------------
    // Address comparison
    // ----------------------------------------
    function automatic logic masked_eq(input logic [7:0] a, input logic [7:0] b, input logic [7:0] m);
        masked_eq = ((a ^ b) & m) == 8'h00;
    endfunction

    assign mode = {mode0_reg, ctrl_reg[UAR_MODE1]};
    // With address and mask both zero every byte matches, which is the reset behaviour
    // that lets plain software drivers work without touching the filter registers.
    assign addr_hit = masked_eq(rx_data, staddr_reg, smask_reg) ||
        masked_eq(rx_data, staddr_reg | smask_reg, staddr_reg | smask_reg);
    assign accept = rx_frame_done && ctrl_reg[UAR_RXEN];
    assign ctrl_wr = reg_wr && reg_addr == UAR_CTRL_OFF;
    assign stat_rd = reg_rd && reg_addr == UAR_IRQ_STAT_OFF;

    // ----------------------------------------
    // Receive qualification
    // ----------------------------------------
    always_comb begin
        rx_set = 1'b0;
        if (accept) begin
            if (mode == UAR_MODE_SHIFT || !ctrl_reg[UAR_FILT]) begin
                rx_set = 1'b1;
            end else if (mode == UAR_MODE_8BIT) begin
                rx_set = rx_stop_ok && addr_hit;
            end else begin
                rx_set = rx_bit9 && addr_hit;
            end
        end
    end
    // A shift-register frame has no stop bit, so it can never be a framing error.
    assign ferr_set = accept && mode != UAR_MODE_SHIFT && !rx_stop_ok;

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    always_comb begin
        staddr_next = staddr_reg;
        smask_next = smask_reg;
        sel_next = sel_reg;
        imask_next = imask_reg;
        if (reg_wr) begin
            if (reg_addr == UAR_STADDR_OFF) begin
                staddr_next = reg_wdata;
            end else if (reg_addr == UAR_SMASK_OFF) begin
                smask_next = reg_wdata;
            end else if (reg_addr == UAR_AUX_OFF) begin
                sel_next = reg_wdata[UAR_AUX_SEL];
            end else if (reg_addr == UAR_IRQ_MASK_OFF) begin
                imask_next = reg_wdata[2:0];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            staddr_reg <= UAR_ADDR_RESET;
            smask_reg <= UAR_ADDR_RESET;
            sel_reg <= 1'b0;
            imask_reg <= 3'h0;
        end else begin
            staddr_reg <= staddr_next;
            smask_reg <= smask_next;
            sel_reg <= sel_next;
            imask_reg <= imask_next;
        end
    end

    // ----------------------------------------
    // Control, flags and received byte
    // ----------------------------------------
    always_comb begin
        ctrl_next = ctrl_reg;
        ferr_next = ferr_reg;
        mode0_next = mode0_reg;
        rxd_next = rxd_reg;
        ist_next = ist_reg;
        if (ctrl_wr) begin
            ctrl_next = reg_wdata;
            // Bit 7 has one storage place per function, so switching the select
            // never turns a stored mode bit into a false framing error.
            if (sel_reg) begin
                ferr_next = reg_wdata[UAR_B7];
            end else begin
                mode0_next = reg_wdata[UAR_B7];
            end
        end
        if (stat_rd) begin
            ist_next = 3'h0;
        end
        // Hardware events are applied last so a set wins over a same-cycle clear.
        if (accept) begin
            rxd_next = rx_data;
            ctrl_next[UAR_RX9] = (mode == UAR_MODE_8BIT) ? rx_stop_ok : rx_bit9;
        end
        if (rx_set) begin
            ctrl_next[UAR_RXDONE] = 1'b1;
            ist_next[UAR_IRQ_RX] = 1'b1;
        end
        if (tx_stop_begin) begin
            ctrl_next[UAR_TXDONE] = 1'b1;
            ist_next[UAR_IRQ_TX] = 1'b1;
        end
        if (ferr_set) begin
            ferr_next = 1'b1;
            ist_next[UAR_IRQ_FERR] = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_reg <= UAR_CTRL_RESET;
            ferr_reg <= 1'b0;
            mode0_reg <= 1'b0;
            rxd_reg <= 8'h00;
            ist_reg <= 3'h0;
        end else begin
            ctrl_reg <= ctrl_next;
            ferr_reg <= ferr_next;
            mode0_reg <= mode0_next;
            rxd_reg <= rxd_next;
            ist_reg <= ist_next;
        end
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    // Read data is zero outside the answer cycle, so a stale value is never mistaken for a reply.
    always_comb begin
        rdata_next = 8'h00;
        if (reg_rd) begin
            if (reg_addr == UAR_CTRL_OFF) begin
                rdata_next = ctrl_reg;
                rdata_next[UAR_B7] = sel_reg ? ferr_reg : mode0_reg;
            end else if (reg_addr == UAR_STADDR_OFF) begin
                rdata_next = staddr_reg;
            end else if (reg_addr == UAR_SMASK_OFF) begin
                rdata_next = smask_reg;
            end else if (reg_addr == UAR_AUX_OFF) begin
                rdata_next = {7'h00, sel_reg};
            end else if (reg_addr == UAR_IRQ_STAT_OFF) begin
                rdata_next = {5'h00, ist_reg};
            end else if (reg_addr == UAR_IRQ_MASK_OFF) begin
                rdata_next = {5'h00, imask_reg};
            end else if (reg_addr == UAR_RXDATA_OFF) begin
                rdata_next = rxd_reg;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign reg_rdata = rdata_reg;
    assign mode_sel = mode;
    assign rx_enable = ctrl_reg[UAR_RXEN];
    // The transmitter is outside this block; it only ever sees the stored ninth bit.
    assign tx_bit9 = ctrl_reg[UAR_TX9];
    assign irq = |(ist_reg & imask_reg);

    // ----------------------------------------
    // Receive checks
    // ----------------------------------------
    rx_flag_filter_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        accept && ctrl_reg[UAR_FILT] && mode[1] && !rx_bit9 && !ctrl_reg[UAR_RXDONE] && !ctrl_wr
        |=> !ctrl_reg[UAR_RXDONE]) else $error("Receive flag set for data frame under filtering.");
    rx_match_set_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        accept && ctrl_reg[UAR_FILT] && mode[1] && rx_bit9 && rx_data == 8'hff
        |=> ctrl_reg[UAR_RXDONE]) else $error("Receive flag missed for broadcast address.");
    rx_flag_open_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        accept && !ctrl_reg[UAR_FILT]
        |=> ctrl_reg[UAR_RXDONE]) else $error("Receive flag missed with filter off.");
    rx_8bit_stop_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        accept && ctrl_reg[UAR_FILT] && mode == UAR_MODE_8BIT && !rx_stop_ok && !ctrl_reg[UAR_RXDONE] && !ctrl_wr
        |=> !ctrl_reg[UAR_RXDONE]) else $error("Receive flag set without stop bit.");
    rx_8bit_hit_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        accept && ctrl_reg[UAR_FILT] && mode == UAR_MODE_8BIT && rx_stop_ok && rx_data == staddr_reg
        |=> ctrl_reg[UAR_RXDONE]) else $error("Receive flag missed for own address.");
    rx_shift_mode_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        accept && mode == UAR_MODE_SHIFT
        |=> ctrl_reg[UAR_RXDONE]) else $error("Receive flag missed in shift mode.");
    rx_disabled_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !ctrl_reg[UAR_RXEN]
        |=> $stable(rxd_reg)) else $error("Received data changed while disabled.");
    rx_data_cap_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        accept
        |=> rxd_reg == $past(rx_data)) else $error("Received byte not captured.");
    given_hit_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        rx_data == staddr_reg
        |-> addr_hit) else $error("Own station address not matched.");
    bcast_hit_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        rx_data == 8'hff
        |-> addr_hit) else $error("Broadcast address not matched.");

    // ----------------------------------------
    // Flag and register checks
    // ----------------------------------------
    fe_sticky_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        ferr_reg && !ctrl_wr
        |=> ferr_reg) else $error("Framing error cleared by hardware.");
    fe_set_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        ferr_set
        |=> ferr_reg) else $error("Framing error not recorded.");
    mode_write_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        ctrl_wr && !sel_reg && reg_wdata[UAR_B7]
        |=> mode_sel[1]) else $error("Mode bit zero not written.");
    mode_keep_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        ctrl_wr && sel_reg
        |=> $stable(mode_sel)) else $error("Mode changed by error flag write.");
    tx_flag_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        tx_stop_begin
        |=> ctrl_reg[UAR_TXDONE]) else $error("Transmit flag not set.");
    tx_ninth_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        ctrl_wr && reg_wdata[UAR_TX9]
        |=> tx_bit9) else $error("Ninth transmit bit not set.");
    tx_ninth_clr_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        ctrl_wr && !reg_wdata[UAR_TX9]
        |=> !tx_bit9) else $error("Ninth transmit bit not cleared.");
    irq_out_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        rx_set && imask_reg[UAR_IRQ_RX]
        |=> irq) else $error("Interrupt output missed.");
    irq_clear_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        stat_rd && !rx_set && !tx_stop_begin && !ferr_set
        |=> !irq) else $error("Status read did not clear interrupt.");
    rdata_idle_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !reg_rd
        |=> reg_rdata == 8'h00) else $error("Read data outside answer cycle.");
endmodule
`default_nettype wire

//--- verilog/uar_pkg.sv
// Constants and register layout for the serial port control and address recognition block.
package uar_pkg;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] UAR_CTRL_OFF = 8'h98;
    localparam logic [7:0] UAR_STADDR_OFF = 8'ha9;
    localparam logic [7:0] UAR_SMASK_OFF = 8'hb9;
    localparam logic [7:0] UAR_AUX_OFF = 8'hc0;
    localparam logic [7:0] UAR_IRQ_STAT_OFF = 8'hc1;
    localparam logic [7:0] UAR_IRQ_MASK_OFF = 8'hc2;
    localparam logic [7:0] UAR_RXDATA_OFF = 8'hc3;
    localparam logic [7:0] UAR_CTRL_RESET = 8'h00;
    localparam logic [7:0] UAR_ADDR_RESET = 8'h00;
    // ----------------------------------------
    // Control and auxiliary register fields
    // ----------------------------------------
    localparam int UAR_B7 = 7;
    localparam int UAR_MODE1 = 6;
    localparam int UAR_FILT = 5;
    localparam int UAR_RXEN = 4;
    localparam int UAR_TX9 = 3;
    localparam int UAR_RX9 = 2;
    localparam int UAR_TXDONE = 1;
    localparam int UAR_RXDONE = 0;
    localparam int UAR_AUX_SEL = 0;
    // Interrupt status bits.
    localparam int UAR_IRQ_RX = 0;
    localparam int UAR_IRQ_TX = 1;
    localparam int UAR_IRQ_FERR = 2;
    typedef enum logic [1:0] {
        UAR_MODE_SHIFT = 2'b00,
        UAR_MODE_8BIT = 2'b01,
        UAR_MODE_9FIX = 2'b10,
        UAR_MODE_9VAR = 2'b11
    } uar_mode_e;
endpackage
